//--- fcs_ctrl.sv
// host-side sequencer driving an 8-bit parallel flash through its pins
`timescale 1ns/100ps
module fcs_ctrl (
	input  wire logic             clk,            // system clock
	input  wire logic             reset,          // sync reset, high
	input  wire logic [3:0]       reg_addr,       // register offset
	input  wire logic [31:0]      reg_wdata,      // write data
	input  wire logic             reg_write,      // write strobe
	input  wire logic             reg_read,       // read strobe
	output logic [31:0]           reg_rdata,      // read data, next cycle
	output fcs_pkg::fcs_pins_t    flash,          // pins to the flash
	input  wire logic [7:0]       flash_dq_in,    // data bus from flash
	input  wire logic             ready_busy_out  // flash ready pin
);
	import fcs_pkg::*;

	fcs_state_t state;
	fcs_state_t next_state;
	fcs_pins_t  next_pins;
	logic [2:0]  op;
	logic [1:0]  step;
	logic [1:0]  next_step;
	logic [19:0] tgt_addr;
	logic [7:0]  tgt_data;
	logic [7:0]  last_status;
	logic [7:0]  read_byte;
	logic        pwrdn;
	logic        lock;
	logic        refused;
	logic        aborted;
	logic        tmr_load;
	logic [7:0]  tmr_val;
	logic        capture;
	logic        op_end;
	wire         tmr_done;
	wire         wake_rd_done;
	wire         wake_wr_done;

	// register decode
	wire         busy      = (state != S_IDLE);
	wire         ctrl_wr   = reg_write && (reg_addr == REG_CTRL);
	wire         go        = ctrl_wr && reg_wdata[CTRL_GO];
	wire [2:0]   new_op    = reg_wdata[CTRL_OP_LO +: 3];
	wire         new_prog  = (new_op == OP_WRITE) || (new_op == OP_ERASE);
	wire         next_pwrdn = ctrl_wr ? reg_wdata[CTRL_PWRDN] : pwrdn;
	wire         pd_enter  = next_pwrdn && !pwrdn;
	wire         wake_load = pwrdn && !next_pwrdn;
	wire         refuse_hit = go && !busy && lock && new_prog;
	wire         accept    = go && !busy && !pwrdn && !refuse_hit &&
		(new_op <= OP_CLEAR);

	// bus cycle plan: every operation opens with a command write
	wire         is_prog   = (op == OP_WRITE) || (op == OP_ERASE);
	wire [1:0]   last_step = is_prog ? 2'd3 :
		((op == OP_CLEAR) ? 2'd0 : 2'd1);
	wire         poll_step = is_prog && (step == 2'd2);
	wire         cyc_write = !(poll_step || (!is_prog && step == 2'd1));
	wire [7:0]   first_cmd =
		(op == OP_WRITE)  ? CMD_WRITE_SETUP :
		(op == OP_ERASE)  ? CMD_ERASE_SETUP :
		(op == OP_STATUS) ? CMD_READ_STATUS :
		(op == OP_CLEAR)  ? CMD_CLEAR_STATUS :
		CMD_READ_ARRAY;
	wire [7:0]   second_cmd = (op == OP_WRITE) ? tgt_data :
		CMD_ERASE_CONFIRM;
	// the closing write puts the device back into array mode
	wire [7:0]   cyc_data  = (step == 2'd0) ? first_cmd :
		(step == 2'd1) ? second_cmd : CMD_READ_ARRAY;
	wire         dev_err   = last_status[SR_SUPPLY_LOW] ||
		last_status[SR_WRITE_ERR] || last_status[SR_ERASE_ERR];

	fcs_delay #(.W(8)) u_phase (
		.clk   (clk),
		.reset (reset),
		.load  (tmr_load),
		.value (tmr_val),
		.done  (tmr_done)
	);

	// wake-up waits restart when the reset pin is raised again
	fcs_delay #(.W(8)) u_wake_rd (
		.clk   (clk),
		.reset (reset),
		.load  (wake_load),
		.value (CYC_WAKE_RD),
		.done  (wake_rd_done)
	);

	fcs_delay #(.W(8)) u_wake_wr (
		.clk   (clk),
		.reset (reset),
		.load  (wake_load),
		.value (CYC_WAKE_WR),
		.done  (wake_wr_done)
	);

	// sequencer: one bus cycle at a time, each closed by a gap
	always_comb
	begin
		next_state = state;
		next_step  = step;
		tmr_load   = 1'b0;
		tmr_val    = 8'h00;
		capture    = 1'b0;
		op_end     = 1'b0;
		case (state)
			S_IDLE:
				if (accept)
				begin
					next_state = S_NEXT;
					next_step  = 2'd0;
				end
			S_NEXT:
				if (cyc_write && wake_wr_done)
				begin
					next_state = S_WR_PULSE;
					tmr_load   = 1'b1;
					tmr_val    = CYC_WE - 8'h01;
				end
				else if (!cyc_write && wake_rd_done &&
					(!poll_step || ready_busy_out))
				begin
					next_state = S_RD_PULSE;
					tmr_load   = 1'b1;
					tmr_val    = CYC_ACC - 8'h01;
				end
			S_WR_PULSE:
				if (tmr_done)
				begin
					next_state = S_WR_GAP;
					tmr_load   = 1'b1;
					tmr_val    = CYC_WGAP - 8'h01;
				end
			S_WR_GAP:
				if (tmr_done && step == last_step)
				begin
					next_state = S_IDLE;
					op_end     = 1'b1;
				end
				else if (tmr_done)
				begin
					next_state = S_NEXT;
					next_step  = step + 2'd1;
				end
			S_RD_PULSE:
				if (tmr_done)
				begin
					capture    = 1'b1;
					next_state = S_RD_GAP;
					tmr_load   = 1'b1;
					tmr_val    = CYC_RGAP - 8'h01;
				end
			S_RD_GAP:
				// a busy poll re-reads after output enable went high
				if (tmr_done && poll_step && !last_status[SR_READY])
					next_state = S_NEXT;
				else if (tmr_done && step == last_step)
				begin
					next_state = S_IDLE;
					op_end     = 1'b1;
				end
				else if (tmr_done)
				begin
					next_state = S_NEXT;
					next_step  = step + 2'd1;
				end
			default:
				next_state = S_IDLE;
		endcase
		// lowering the reset pin abandons the sequence at once; an
		// aborted sequence neither ends nor captures; the aborted flag sets and pd_enter resets status and lock
		if (next_pwrdn)
		begin
			next_state = S_IDLE;
			op_end     = 1'b0;
			capture    = 1'b0;
		end
	end

	// pin values follow the state they belong to, registered
	always_comb
	begin
		next_pins.addr   = tgt_addr;
		next_pins.dq_out = cyc_data;
		next_pins.dq_oe  = (next_state == S_WR_PULSE) ||
			(next_state == S_WR_GAP);
		// both enables low together only in a write pulse, command or data byte
		next_pins.we_n   = !(next_state == S_WR_PULSE);
		next_pins.oe_n   = !(next_state == S_RD_PULSE);
		next_pins.ce_n   = !((next_state == S_WR_PULSE) ||
			(next_state == S_RD_PULSE));
		next_pins.powerdown_reset_n = !next_pwrdn;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state <= S_IDLE;
			step  <= 2'd0;
			flash <= '{addr: 20'h00000, dq_out: 8'h00, dq_oe: 1'b0,
				ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
				powerdown_reset_n: 1'b1};
		end
		else
		begin
			state <= next_state;
			step  <= next_step;
			flash <= next_pins;
		end
	end

	// software-written operands, frozen while a sequence runs
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			op       <= OP_READ;
			tgt_addr <= 20'h00000;
			tgt_data <= 8'h00;
			pwrdn    <= 1'b0;
		end
		else
		begin
			pwrdn <= next_pwrdn;
			if (accept)
				op <= new_op;
			if (reg_write && reg_addr == REG_ADDR && !busy)
				tgt_addr <= reg_wdata[19:0];
			if (reg_write && reg_addr == REG_DATA && !busy)
				tgt_data <= reg_wdata[7:0];
		end
	end

	// status mirror: the device byte plus the controller's own flags
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			last_status <= SR_RESET_VAL;
			read_byte   <= 8'h00;
		end
		else if (pd_enter)
			last_status <= SR_RESET_VAL;
		else
		begin
			if (capture && (poll_step || op == OP_STATUS))
				last_status <= flash_dq_in;
			else if (op_end && op == OP_CLEAR)
			begin
				last_status[SR_SUPPLY_LOW] <= 1'b0;
				last_status[SR_WRITE_ERR]  <= 1'b0;
				last_status[SR_ERASE_ERR]  <= 1'b0;
			end
			if (capture && op == OP_READ)
				read_byte <= flash_dq_in;
		end
	end

	// the lock keeps software from retrying before it clears status
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			lock    <= 1'b0;
			refused <= 1'b0;
			aborted <= 1'b0;
		end
		else
		begin
			if (op_end && is_prog && dev_err)
				lock <= 1'b1;
			else if (pd_enter || (op_end && op == OP_CLEAR))
				lock <= 1'b0;
			if (refuse_hit)
				refused <= 1'b1;
			else if (accept)
				refused <= 1'b0;
			if (pd_enter && busy)
				aborted <= 1'b1;
			else if (accept)
				aborted <= 1'b0;
		end
	end

	// read data, one cycle after the strobe; unmapped offsets give zero
	wire [31:0] stat_word = {16'h0000, last_status, 2'b00,
		!(wake_rd_done && wake_wr_done),
		last_status[SR_ERASE_ERR] && last_status[SR_WRITE_ERR],
		aborted, refused, lock, busy};
	wire [31:0] rd_mux =
		(reg_addr == REG_CTRL) ? {24'h000000, pwrdn, 3'b000, op, 1'b0} :
		(reg_addr == REG_ADDR) ? {12'h000, tgt_addr} :
		(reg_addr == REG_DATA) ? {24'h000000, read_byte} :
		(reg_addr == REG_STAT) ? stat_word : 32'h00000000;

	always_ff @(posedge clk)
	begin
		if (reset)
			reg_rdata <= 32'h00000000;
		else if (reg_read)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= 32'h00000000;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_WE_WITH_CE: assert property (
		!flash.we_n |-> !flash.ce_n && flash.dq_oe)
		else $error("write strobe without chip enable");
	AST_WE_WIDTH: assert property (
		$fell(flash.we_n) |-> !flash.we_n[*2] ##1 flash.we_n)
		else $error("write pulse width wrong");
	AST_PD_QUIET: assert property (
		!flash.powerdown_reset_n |->
		flash.ce_n && flash.we_n && flash.oe_n)
		else $error("control active during power-down");
	AST_WAKE_WAIT: assert property (
		$rose(flash.powerdown_reset_n) |->
		(flash.we_n && flash.oe_n)[*8])
		else $error("access too soon after wake");
	AST_REFUSE: assert property (
		refuse_hit |=> state == S_IDLE && refused)
		else $error("locked program operation started");
	AST_CONFIRM: assert property (
		$fell(flash.we_n) && op == OP_ERASE && step == 2'd1 |->
		flash.dq_out == CMD_ERASE_CONFIRM)
		else $error("erase setup not followed by confirm");
	AST_REPOLL: assert property (
		state == S_RD_GAP && tmr_done && poll_step &&
		!last_status[SR_READY] && !next_pwrdn |=>
		state == S_NEXT && step == 2'd2 && flash.oe_n)
		else $error("busy poll did not re-read");
	AST_CLOSE_ARRAY: assert property (
		op_end && is_prog && !next_pwrdn |->
		$past(flash.dq_out, 2) == CMD_READ_ARRAY)
		else $error("program operation not closed by read-array");
	AST_ERR_LOCK: assert property (
		op_end && is_prog && dev_err |=> lock)
		else $error("error did not lock the controller");
	AST_PD_STATUS: assert property (
		pd_enter |=> last_status == SR_RESET_VAL && !lock &&
		state == S_IDLE)
		else $error("power-down did not restore status");

	COV_ERASE_DONE: cover property (op_end && op == OP_ERASE);
	COV_REPOLL: cover property (state == S_RD_GAP ##1
		state == S_NEXT ##[1:20] state == S_RD_PULSE);
	COV_REFUSE: cover property (refuse_hit);
	COV_ABORT: cover property (pd_enter && busy);
endmodule

//--- fcs_pkg.sv
// constants, register map and carrier types of the flash command sequencer
package fcs_pkg;
	// bus timing of the flash pins, 40 MHz clock
	localparam int CLK_PERIOD_NS = 25;
	localparam int T_WE_NS       = 50;
	localparam int T_WGAP_NS     = 50;
	localparam int T_ACC_NS      = 150;
	localparam int T_RGAP_NS     = 50;
	localparam int T_WAKE_RD_NS  = 1000;
	localparam int T_WAKE_WR_NS  = 500;
	localparam logic [7:0] CYC_WE      =
		8'((T_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] CYC_WGAP    =
		8'((T_WGAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] CYC_ACC     =
		8'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] CYC_RGAP    =
		8'((T_RGAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] CYC_WAKE_RD =
		8'((T_WAKE_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] CYC_WAKE_WR =
		8'((T_WAKE_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// software register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h4;
	localparam logic [3:0] REG_DATA = 4'h8;
	localparam logic [3:0] REG_STAT = 4'hc;
	// control fields
	localparam int CTRL_GO    = 0;
	localparam int CTRL_OP_LO = 1;
	localparam int CTRL_PWRDN = 7;
	// controller status fields
	localparam int ST_BUSY    = 0;
	localparam int ST_LOCK    = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_ABORT   = 3;
	localparam int ST_SEQERR  = 4;
	localparam int ST_WAKING  = 5;
	localparam int ST_DEV_LO  = 8;
	// operation codes written into the control register
	localparam logic [2:0] OP_READ   = 3'h0;
	localparam logic [2:0] OP_WRITE  = 3'h1;
	localparam logic [2:0] OP_ERASE  = 3'h2;
	localparam logic [2:0] OP_STATUS = 3'h3;
	localparam logic [2:0] OP_CLEAR  = 3'h4;

	// device status byte layout
	localparam int SR_READY      = 7;
	localparam int SR_ERASE_ERR  = 5;
	localparam int SR_WRITE_ERR  = 4;
	localparam int SR_SUPPLY_LOW = 3;
	localparam logic [7:0] SR_RESET_VAL = 8'h80;
	// device command codes
	localparam logic [7:0] CMD_READ_ARRAY    = 8'hff;
	localparam logic [7:0] CMD_WRITE_SETUP   = 8'h40;
	localparam logic [7:0] CMD_ERASE_SETUP   = 8'h20;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;

	typedef enum logic [2:0] {
		S_IDLE, S_NEXT, S_WR_PULSE, S_WR_GAP, S_RD_PULSE, S_RD_GAP
	} fcs_state_t;

	// pins driven towards the flash
	typedef struct packed {
		logic [19:0] addr;
		logic [7:0]  dq_out;
		logic        dq_oe;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        powerdown_reset_n;
	} fcs_pins_t;
endpackage

//--- fcs_delay.sv
// loadable down counter used for pulse widths and wake-up waits
`timescale 1ns/100ps
module fcs_delay #(
	parameter int W = 8
) (
	input  wire logic         clk,   // system clock
	input  wire logic         reset, // synchronous reset, high
	input  wire logic         load,  // restart the wait
	input  wire logic [W-1:0] value, // cycles to wait after load
	output logic              done   // count has run out
);
	logic [W-1:0] count;

	// after reset the counter is empty, so nothing waits on power-up
	always_ff @(posedge clk)
	begin
		if (reset)
			count <= '0;
		else if (load)
			count <= value;
		else if (count != '0)
			count <= count - 1'b1;
	end

	assign done = (count == '0);
endmodule

//--- fcs_flash_model.sv
// behavioural flash device facing the sequencer pins
`timescale 1ns/100ps
module fcs_flash_model (
	input	wire logic		clk,		// system clock
	input	fcs_pkg::fcs_pins_t	pins,		// pins from sequencer
	input	wire logic		supply_low,	// program supply low
	input	wire logic		inject_fail,	// verify fails
	input	wire logic [7:0]	busy_len,	// cycles an op lasts
	output	logic [7:0]		dq,		// data towards sequencer
	output	logic			ready_busy_out	// high when idle
);
	import fcs_pkg::*;
	logic [7:0]	sr = SR_RESET_VAL;
	logic [7:0]	mem [16];
	logic [7:0]	cnt = 8'h00;
	logic [7:0]	last = 8'h00;
	logic [7:0]	cd = 8'h00;
	logic [3:0]	ca = 4'h0;
	logic		smode = 1'h0;
	logic		pw = 1'h0;
	logic		pe = 1'h0;
	logic		low = 1'h0;
	wire		rst_n = pins.powerdown_reset_n;
	wire		wr_end = low && pins.we_n;
	wire		rd_on = rst_n && !pins.ce_n && !pins.oe_n;
	wire		ok = !supply_low && !sr[3];
	wire [7:0]	stat = {cnt == 8'h00, sr[6:0]};

	initial
		foreach (mem[i]) mem[i] = 8'hff;
	assign ready_busy_out = !rst_n || cnt == 8'h00;
	// released bus shows the inverse, so a stale byte never passes
	assign dq = rd_on ? (smode ? stat : mem[ca]) : ~last;

	// command decoder; state changes on accepted writes, on the busy count and while the reset pin is low
	always @(posedge clk)
	begin
		low <= rst_n && !pins.we_n && !pins.ce_n;
		if (rd_on)
			last <= dq;
		if (low || !pins.oe_n)
			ca <= pins.addr[3:0];
		if (low)
			cd <= pins.dq_out;
		if (!rst_n)
		begin
			if (cnt != 8'h00)
				mem[ca] <= mem[ca] ^ 8'h0f;
			sr <= SR_RESET_VAL;
			cnt <= 8'h00;
			smode <= 1'h0;
			pw <= 1'h0;
			pe <= 1'h0;
		end
		else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
		else if (wr_end)
		begin
			pw <= 1'h0;
			pe <= 1'h0;
			if (pw || pe)
				smode <= 1'h1;
			if (pe && cd != CMD_ERASE_CONFIRM)
				sr[5:4] <= 2'h3;
			else if ((pw || pe) && supply_low)
				sr[3] <= 1'h1;
			else if ((pw || pe) && ok)
			begin
				cnt <= busy_len;
				if (inject_fail)
					sr[pw ? 4 : 5] <= 1'h1;
				else if (pw)
					mem[ca] <= mem[ca] & cd;
				else
					foreach (mem[i]) mem[i] <= 8'hff;
			end
			else if (!pw && !pe)
				case (cd)
				CMD_WRITE_SETUP, 8'h10: pw <= 1'h1;
				CMD_ERASE_SETUP: pe <= 1'h1;
				CMD_READ_STATUS: smode <= 1'h1;
				CMD_CLEAR_STATUS: sr[5:3] <= 3'h0;
				CMD_READ_ARRAY: smode <= 1'h0;
				default: ;
				endcase
		end
	end
endmodule

//--- tb_fcs_ctrl.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/100ps
module tb_fcs_ctrl;
	import fcs_pkg::*;
	typedef struct {
		logic [2:0]	op;
		logic [19:0]	addr;
		logic [7:0]	data;
		logic		fail;
		logic		low;
		logic [8:0]	exp_st;
		logic [7:0]	exp_rd;
	} fcs_row_t;
	logic		clk = 1'h0;
	logic		reset = 1'h1;
	logic		reg_write = 1'h0;
	logic		reg_read = 1'h0;
	logic [3:0]	reg_addr = 4'h0;
	logic [31:0]	reg_wdata = 32'h0;
	logic [31:0]	reg_rdata;
	logic [31:0]	st;
	fcs_pins_t	flash;
	logic [7:0]	flash_dq_in;
	logic [7:0]	busy_len = 8'h04;
	logic		ready_busy_out;
	logic		supply_low = 1'h0;
	logic		inject_fail = 1'h0;
	int		fail_count = 0;
	int		checks = 0;
	int		cycles = 0;
	fcs_row_t	rows [10];

	always #12.5 clk = ~clk;

	fcs_ctrl uut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .flash(flash),
		.flash_dq_in(flash_dq_in), .ready_busy_out(ready_busy_out));
	fcs_flash_model dev (.clk(clk), .pins(flash),
		.supply_low(supply_low), .inject_fail(inject_fail),
		.busy_len(busy_len), .dq(flash_dq_in),
		.ready_busy_out(ready_busy_out));

	task automatic chk(input string nm, input logic [31:0] got, exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge clk);
		reg_write <= 1'h0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge clk);
		reg_read <= 1'h0;
		@(negedge clk);
		d = reg_rdata;
	endtask

	// start an operation and poll the busy bit, bounded
	task automatic run(input logic [2:0] op);
		int n;
		wr(REG_CTRL, {28'h0, op, 1'h1});
		n = 0;
		do
		begin
			rd(REG_STAT, st);
			n++;
		end
		while (st[ST_BUSY] !== 1'h0 && n < 500);
		chk("done", st[ST_BUSY], 1'h0);
	endtask

	task automatic stop_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// hang guard, well above the several hundred cycles needed
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			fail_count++;
			stop_test();
		end
	end

	initial
	begin
		int n;
		rows[0] = '{OP_WRITE, 20'h3, 8'h5a, 1'h0, 1'h0, 9'h100, 8'h0};
		rows[1] = '{OP_READ, 20'h3, 8'h0, 1'h0, 1'h0, 9'h100, 8'h5a};
		rows[2] = '{OP_ERASE, 20'h3, 8'h0, 1'h0, 1'h0, 9'h100, 8'h0};
		rows[3] = '{OP_READ, 20'h3, 8'h0, 1'h0, 1'h0, 9'h100, 8'hff};
		rows[4] = '{OP_STATUS, 20'h3, 8'h0, 1'h0, 1'h0, 9'h100, 8'h0};
		rows[5] = '{OP_WRITE, 20'h4, 8'h33, 1'h1, 1'h0, 9'h121, 8'h0};
		rows[6] = '{OP_CLEAR, 20'h4, 8'h0, 1'h0, 1'h0, 9'h100, 8'h0};
		rows[7] = '{OP_ERASE, 20'h4, 8'h0, 1'h0, 1'h1, 9'h111, 8'h0};
		rows[8] = '{OP_CLEAR, 20'h4, 8'h0, 1'h0, 1'h0, 9'h100, 8'h0};
		rows[9] = '{OP_ERASE, 20'h4, 8'h0, 1'h1, 1'h0, 9'h141, 8'h0};
		repeat (7) @(posedge clk);
		@(negedge clk);
		chk("idle pins", {flash.ce_n, flash.we_n, flash.dq_oe,
			flash.powerdown_reset_n}, 4'hd);
		@(posedge clk);
		reset <= 1'h0;
		rd(REG_STAT, st);
		chk("reset stat", st, 32'h8000);
		foreach (rows[i])
		begin
			supply_low <= rows[i].low;
			inject_fail <= rows[i].fail;
			wr(REG_ADDR, {12'h0, rows[i].addr});
			wr(REG_DATA, {24'h0, rows[i].data});
			run(rows[i].op);
			chk("status", {st[15:8], st[ST_LOCK]}, rows[i].exp_st);
			chk("addr", flash.addr, rows[i].addr);
			if (rows[i].op == OP_READ)
			begin
				rd(REG_DATA, st);
				chk("array", st, rows[i].exp_rd);
			end
		end
		// locked after the failed erase: a write must be refused
		inject_fail <= 1'h0;
		run(OP_WRITE);
		chk("refused", {st[15:8], st[ST_REFUSED]}, 9'h141);
		run(OP_CLEAR);
		chk("cleared", {st[15:8], st[ST_LOCK]}, 9'h100);
		// power down in the middle of a long erase
		busy_len <= 8'hc8;
		wr(REG_CTRL, {28'h0, OP_ERASE, 1'h1});
		n = 0;
		while (ready_busy_out !== 1'h0 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		chk("erasing", ready_busy_out, 1'h0);
		wr(REG_CTRL, 32'h80);
		@(negedge clk);
		chk("reset pin", flash.powerdown_reset_n, 1'h0);
		rd(REG_STAT, st);
		chk("abort", {st[15:8], st[ST_ABORT], st[ST_BUSY]}, 10'h202);
		wr(REG_CTRL, 32'h0);
		rd(REG_STAT, st);
		chk("waking", st[ST_WAKING], 1'h1);
		busy_len <= 8'h04;
		run(OP_STATUS);
		chk("wake stat", st[15:8], 8'h80);
		stop_test();
	end
endmodule
